// ===== rtl/bad_pkg.sv
// Constants shared by the board address decoder
package bad_pkg;

    // ****************************************
    // Bus widths
    // ****************************************
    localparam int IO_AW  = 16;  // Full I/O space
    localparam int MEM_AW = 20;  // First megabyte
    localparam int DW     = 8;   // Data path and DMA width

    // ****************************************
    // I/O port addresses
    // ****************************************
    localparam logic [15:0] IO_SPEAKER    = 16'h0061;
    localparam logic [15:0] IO_NMI_MASK   = 16'h00A0;
    localparam logic [15:0] IO_FLASH_CTRL = 16'h0180;
    localparam logic [15:0] IO_FLASH_PAGE = 16'h0181;

    // ****************************************
    // Register fields and reset values
    // ****************************************
    localparam int          SPK_W        = 2;      // Bits 0 and 1 only
    localparam logic [1:0]  SPK_RST      = 2'h0;
    localparam int          NMI_BIT      = 7;      // Enable bit position
    localparam logic [7:0]  NMI_ON       = 8'h80;
    localparam logic [7:0]  NMI_OFF      = 8'h00;
    localparam logic        NMI_RST      = 1'h0;
    localparam int          CTRL_WIN_BIT = 0;      // User flash window
    localparam int          CTRL_DSK_BIT = 1;      // Flash-disk select
    localparam logic [1:0]  CTRL_RST     = 2'h0;
    localparam logic [6:0]  PAGE_RST     = 7'h00;

    // ****************************************
    // Memory regions, by upper address bits
    // ****************************************
    localparam logic [3:0]  MEM_OPT      = 4'hC;   // C0000-CFFFF
    localparam logic [3:0]  MEM_WIN      = 4'hD;   // D0000-DFFFF
    localparam logic [3:0]  MEM_BIOS     = 4'hF;   // F0000-FFFFF
    localparam logic [4:0]  MEM_FREE_E   = 5'h1C;  // E0000-E7FFF
    localparam logic [4:0]  MEM_DISK     = 5'h1D;  // E8000-EFFFF
    localparam logic [1:0]  BOOT_PG_OPT  = 2'h0;   // First 64K page
    localparam logic [1:0]  BOOT_PG_BIOS = 2'h3;   // Fourth 64K page

    // ****************************************
    // Interrupt and DMA counts
    // ****************************************
    localparam int NUM_IRQ = 8;
    localparam int NUM_DMA = 3;  // Channel 3 is absent

endpackage : bad_pkg

// ===== rtl/bad_decoder.sv
// Board address decoder: memory and I/O routing, glue ports, IRQ/DMA
// ****************************************
// ****************************************
module bad_decoder #(
    parameter int NUM_PAGES = 128  // User flash pages
) (
    // Clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      rstn_i,
    // Memory cycle
    input  wire logic                      mem_rd_i,
    input  wire logic                      mem_wr_i,
    input  wire logic [bad_pkg::MEM_AW-1:0] mem_addr_i,
    // I/O cycle
    input  wire logic                      io_rd_i,
    input  wire logic                      io_wr_i,
    input  wire logic [bad_pkg::IO_AW-1:0] io_addr_i,
    input  wire logic [bad_pkg::DW-1:0]    io_wdata_i,
    output logic      [bad_pkg::DW-1:0]    io_rdata_o,
    output logic                           io_claim_o,
    // Memory selects
    output logic                           boot_flash_cs_o,
    output logic      [1:0]                boot_page_o,
    output logic                           user_flash_cs_o,
    output logic      [6:0]                user_page_o,
    output logic                           flash_disk_cs_o,
    output logic                           ext_bus_sel_o,
    // Glue outputs
    output logic      [bad_pkg::SPK_W-1:0] speaker_o,
    output logic                           nmi_enable_o,
    // Interrupt sources and edges to the controller
    input  wire logic [bad_pkg::NUM_IRQ-1:0] irq_src_i,
    output logic      [bad_pkg::NUM_IRQ-1:0] irq_edge_o,
    // DMA requests, channels 0 to 2
    input  wire logic [bad_pkg::NUM_DMA-1:0] dma_src_i,
    output logic      [bad_pkg::NUM_DMA-1:0] dma_req_o
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    // Page register is seven bits wide
    if (NUM_PAGES < 1 || NUM_PAGES > 128) begin : g_bad_pages
        $error("NUM_PAGES must be 1 to 128");
    end

    // ****************************************
    // Decode helpers
    // ****************************************
    // Exact match over the whole I/O space
    function automatic logic io_hit(
        input logic [bad_pkg::IO_AW-1:0] addr,
        input logic [bad_pkg::IO_AW-1:0] port
    );
        return addr == port;
    endfunction : io_hit

    // Match on the top nibble of a memory address
    function automatic logic mem_hit64(
        input logic [bad_pkg::MEM_AW-1:0] addr,
        input logic [3:0]                 nib
    );
        return addr[19:16] == nib;
    endfunction : mem_hit64

    // ****************************************
    // Registers
    // ****************************************
    logic [bad_pkg::SPK_W-1:0] spk_q;   // Speaker bits
    logic                      nmi_q;   // NMI pass enable
    logic                      win_q;   // User window enable
    logic                      dsk_q;   // Flash-disk enable
    logic [6:0]                page_q;  // User page number
    logic [bad_pkg::NUM_IRQ-1:0] irq_q; // Last source level

    // Port hits, shared by write and read paths
    logic hit_spk;
    logic hit_nmi;
    logic hit_ctl;
    logic hit_pg;

    assign hit_spk = io_hit(io_addr_i, bad_pkg::IO_SPEAKER);
    assign hit_nmi = io_hit(io_addr_i, bad_pkg::IO_NMI_MASK);
    assign hit_ctl = io_hit(io_addr_i, bad_pkg::IO_FLASH_CTRL);
    assign hit_pg  = io_hit(io_addr_i, bad_pkg::IO_FLASH_PAGE);

    // ****************************************
    // Speaker port
    // ****************************************
    // Only the low two bits exist; others are dropped
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            spk_q <= bad_pkg::SPK_RST;
        end
        else if (io_wr_i && hit_spk)
        begin
            spk_q <= io_wdata_i[bad_pkg::SPK_W-1:0];
        end
    end

    // ****************************************
    // NMI mask port
    // ****************************************
    // Bit 7 decides, so 80h opens and 00h blocks the NMI;
    // starts blocked so no NMI fires before software is ready
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            nmi_q <= bad_pkg::NMI_RST;
        end
        else if (io_wr_i && hit_nmi)
        begin
            nmi_q <= io_wdata_i[bad_pkg::NMI_BIT];
        end
    end

    // ****************************************
    // Flash control and page ports
    // ****************************************
    // Both enables come out of reset cleared
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            win_q <= bad_pkg::CTRL_RST[bad_pkg::CTRL_WIN_BIT];
            dsk_q <= bad_pkg::CTRL_RST[bad_pkg::CTRL_DSK_BIT];
        end
        else if (io_wr_i && hit_ctl)
        begin
            win_q <= io_wdata_i[bad_pkg::CTRL_WIN_BIT];
            dsk_q <= io_wdata_i[bad_pkg::CTRL_DSK_BIT];
        end
    end

    // Page number; values past the last page wrap to keep range
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            page_q <= bad_pkg::PAGE_RST;
        end
        else if (io_wr_i && hit_pg)
        begin
            page_q <= 7'(io_wdata_i[6:0] % 8'(NUM_PAGES));
        end
    end

    // ****************************************
    // I/O read data and claim
    // ****************************************
    // Unmatched ports are not claimed and read zero
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            io_rdata_o <= 8'h00;
            io_claim_o <= 1'b0;
        end
        else
        begin
            io_claim_o <= (io_rd_i || io_wr_i) &&
                          (hit_spk || hit_nmi || hit_ctl || hit_pg);
            io_rdata_o <= 8'h00;
            if (io_rd_i)
            begin
                if (hit_spk)
                begin
                    io_rdata_o <= {6'h00, spk_q};
                end
                else if (hit_nmi)
                begin
                    io_rdata_o <= nmi_q ? bad_pkg::NMI_ON : bad_pkg::NMI_OFF;
                end
                else if (hit_ctl)
                begin
                    io_rdata_o <= {6'h00, dsk_q, win_q};
                end
                else if (hit_pg)
                begin
                    io_rdata_o <= {1'b0, page_q};
                end
            end
        end
    end

    // ****************************************
    // Memory region decode
    // ****************************************
    // One cycle of latency buys registered, glitch-free selects
    logic mem_cyc;
    logic in_opt;
    logic in_win;
    logic in_bios;
    logic in_disk;

    assign mem_cyc = mem_rd_i || mem_wr_i;
    assign in_opt  = mem_hit64(mem_addr_i, bad_pkg::MEM_OPT);
    assign in_win  = mem_hit64(mem_addr_i, bad_pkg::MEM_WIN);
    assign in_bios = mem_hit64(mem_addr_i, bad_pkg::MEM_BIOS);
    // E0000-E7FFF matches nothing here and stays external
    assign in_disk = mem_addr_i[19:15] == bad_pkg::MEM_DISK;

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            boot_flash_cs_o <= 1'b0;
            boot_page_o     <= bad_pkg::BOOT_PG_OPT;
            user_flash_cs_o <= 1'b0;
            user_page_o     <= bad_pkg::PAGE_RST;
            flash_disk_cs_o <= 1'b0;
            ext_bus_sel_o   <= 1'b0;
        end
        else
        begin
            // Default: nothing on board selected
            boot_flash_cs_o <= 1'b0;
            user_flash_cs_o <= 1'b0;
            flash_disk_cs_o <= 1'b0;
            ext_bus_sel_o   <= mem_cyc;
            user_page_o     <= page_q;
            if (mem_rd_i && in_opt)
            begin
                // Option region reads from boot page 0
                boot_flash_cs_o <= 1'b1;
                boot_page_o     <= bad_pkg::BOOT_PG_OPT;
                ext_bus_sel_o   <= 1'b0;
            end
            else if (mem_cyc && in_bios)
            begin
                boot_flash_cs_o <= 1'b1;
                boot_page_o     <= bad_pkg::BOOT_PG_BIOS;
                ext_bus_sel_o   <= 1'b0;
            end
            else if (mem_cyc && in_win && win_q)
            begin
                // Disabled window falls through to external bus
                user_flash_cs_o <= 1'b1;
                ext_bus_sel_o   <= 1'b0;
            end
            else if (mem_cyc && in_disk && dsk_q)
            begin
                // No socket fitted: software leaves this off
                flash_disk_cs_o <= 1'b1;
                ext_bus_sel_o   <= 1'b0;
            end
        end
    end

    // ****************************************
    // Glue outputs
    // ****************************************
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            speaker_o    <= bad_pkg::SPK_RST;
            nmi_enable_o <= bad_pkg::NMI_RST;
        end
        else
        begin
            speaker_o    <= spk_q;
            nmi_enable_o <= nmi_q;
        end
    end

    // ****************************************
    // Interrupt edge generation
    // ****************************************
    // The controller is edge-triggered, so a held level
    // becomes one pulse on its rising edge
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_q      <= '0;
            irq_edge_o <= '0;
        end
        else
        begin
            irq_q      <= irq_src_i;
            irq_edge_o <= irq_src_i & ~irq_q;
        end
    end

    // ****************************************
    // DMA request routing
    // ****************************************
    // Three 8-bit channels only; channel 3 pins belong
    // to another unit so there is no port for it.
    // Parallel port software should take channel 1.
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            dma_req_o <= '0;
        end
        else
        begin
            dma_req_o <= dma_src_i;
        end
    end

endmodule : bad_decoder

// ===== bench/bad_decoder_assertions.sv
// Port checker for the board address decoder
module bad_decoder_assertions #(
    parameter int NUM_PAGES = 128  // User flash pages
) (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        rstn_i,
    // Processor cycles
    input wire logic        mem_rd_i,
    input wire logic        mem_wr_i,
    input wire logic [19:0] mem_addr_i,
    input wire logic        io_rd_i,
    input wire logic        io_wr_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0]  io_wdata_i,
    // Decoder outputs
    input wire logic        io_claim_o,
    input wire logic        boot_flash_cs_o,
    input wire logic [1:0]  boot_page_o,
    input wire logic        user_flash_cs_o,
    input wire logic        flash_disk_cs_o,
    input wire logic        ext_bus_sel_o,
    input wire logic [1:0]  speaker_o,
    input wire logic        nmi_enable_o,
    // Interrupts and DMA
    input wire logic [7:0]  irq_src_i,
    input wire logic [7:0]  irq_edge_o,
    input wire logic [2:0]  dma_src_i,
    input wire logic [2:0]  dma_req_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Properties, all on the one clock
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    AST_SPK_CLAIM: assert property (
        (io_rd_i || io_wr_i) && io_addr_i == 16'h0061 |=> io_claim_o)
        else $error("speaker port not claimed");
    AST_SPK_BITS: assert property (
        // Register then output stage: the pin follows two edges after the write
        io_wr_i && io_addr_i == 16'h0061 |-> ##2 speaker_o == $past(io_wdata_i[1:0], 2))
        else $error("speaker bits not stored");
    AST_ALIAS: assert property (
        (io_rd_i || io_wr_i) && io_addr_i == 16'h1061 |=> !io_claim_o)
        else $error("partial I/O decode");
    AST_NMI: assert property (
        io_wr_i && io_addr_i == 16'h00A0 |-> ##2 nmi_enable_o == $past(io_wdata_i[7], 2))
        else $error("nmi mask not stored");
    AST_OPT: assert property (
        mem_rd_i && !mem_wr_i && mem_addr_i[19:16] == 4'hC
        |=> boot_flash_cs_o && boot_page_o == 2'h0)
        else $error("option read missed boot page 0");
    AST_BIOS: assert property (
        (mem_rd_i || mem_wr_i) && mem_addr_i[19:16] == 4'hF
        |=> boot_flash_cs_o && boot_page_o == 2'h3)
        else $error("top region missed boot page 3");
    AST_FREE: assert property (
        (mem_rd_i || mem_wr_i) && mem_addr_i[19:15] == 5'h1C
        |=> ext_bus_sel_o && !boot_flash_cs_o && !user_flash_cs_o && !flash_disk_cs_o)
        else $error("free region claimed on board");
    AST_UNMAPPED: assert property (
        (mem_rd_i || mem_wr_i) && mem_addr_i[19:16] == 4'hA
        |=> ext_bus_sel_o && !boot_flash_cs_o && !user_flash_cs_o && !flash_disk_cs_o)
        else $error("unmapped memory claimed on board");
    AST_IRQ: assert property (
        $rose(irq_src_i[3]) |=> irq_edge_o[3] ##1 !irq_edge_o[3])
        else $error("interrupt not a single pulse");
    AST_DMA: assert property (
        1'b1 |=> dma_req_o == $past(dma_src_i))
        else $error("dma request not passed");
endmodule : bad_decoder_assertions

bind bad_decoder bad_decoder_assertions #(.NUM_PAGES(NUM_PAGES)) chk (
    .clock_i(clock_i), .rstn_i(rstn_i), .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i),
    .mem_addr_i(mem_addr_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_claim_o(io_claim_o), .boot_flash_cs_o(boot_flash_cs_o),
    .boot_page_o(boot_page_o), .user_flash_cs_o(user_flash_cs_o),
    .flash_disk_cs_o(flash_disk_cs_o), .ext_bus_sel_o(ext_bus_sel_o),
    .speaker_o(speaker_o), .nmi_enable_o(nmi_enable_o), .irq_src_i(irq_src_i),
    .irq_edge_o(irq_edge_o), .dma_src_i(dma_src_i), .dma_req_o(dma_req_o));

// ===== bench/bad_cpu_model.sv
// Processor bus model issuing memory and I/O cycles
module bad_cpu_model (
    input  wire logic        clock_i,
    output logic             mem_rd_o,
    output logic             mem_wr_o,
    output logic      [19:0] mem_addr_o,
    output logic             io_rd_o,
    output logic             io_wr_o,
    output logic      [15:0] io_addr_o,
    output logic      [7:0]  io_wdata_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Bus cycles, one clock each
    // ****************************************
    initial
    begin
        {mem_rd_o, mem_wr_o, io_rd_o, io_wr_o} = 4'h0;
        mem_addr_o = 20'h00000;
        io_addr_o  = 16'h0000;
        io_wdata_o = 8'h00;
    end

    // Released lines show the inverse so stale values never match
    task io_cyc(input logic rd, input logic wr, input logic [15:0] a,
                input logic [7:0] d);
        @(negedge clock_i);
        {io_rd_o, io_wr_o, io_addr_o, io_wdata_o} = {rd, wr, a, d};
        @(negedge clock_i);
        {io_rd_o, io_wr_o, io_addr_o, io_wdata_o} = {2'h0, ~a, ~d};
    endtask : io_cyc

    task mem_cyc(input logic rd, input logic wr, input logic [19:0] a);
        @(negedge clock_i);
        {mem_rd_o, mem_wr_o, mem_addr_o} = {rd, wr, a};
        @(negedge clock_i);
        {mem_rd_o, mem_wr_o, mem_addr_o} = {2'h0, ~a};
    endtask : mem_cyc
endmodule : bad_cpu_model

// ===== bench/board_address_decoder_test.sv
// Self-checking bench for the board address decoder
module board_address_decoder_test;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // Signals, named as the decoder ports
    // ****************************************
    logic        clock_i = 1'b0, rstn_i = 1'b0;
    logic        mem_rd_i, mem_wr_i, io_rd_i, io_wr_i, io_claim_o;
    logic [19:0] mem_addr_i;
    logic [15:0] io_addr_i;
    logic [7:0]  io_wdata_i, io_rdata_o, irq_edge_o, irq_src_i = 8'h00;
    logic        boot_flash_cs_o, user_flash_cs_o, flash_disk_cs_o;
    logic        ext_bus_sel_o, nmi_enable_o;
    logic [1:0]  boot_page_o, speaker_o;
    logic [6:0]  user_page_o;
    logic [2:0]  dma_src_i = 3'h0, dma_req_o;
    int          mismatches = 0, n_compared = 0;

    always #12.5 clock_i = ~clock_i;

    bad_decoder #(.NUM_PAGES(128)) DUT (
        .clock_i(clock_i), .rstn_i(rstn_i), .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i),
        .mem_addr_i(mem_addr_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i),
        .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
        .io_claim_o(io_claim_o), .boot_flash_cs_o(boot_flash_cs_o),
        .boot_page_o(boot_page_o), .user_flash_cs_o(user_flash_cs_o),
        .user_page_o(user_page_o), .flash_disk_cs_o(flash_disk_cs_o),
        .ext_bus_sel_o(ext_bus_sel_o), .speaker_o(speaker_o),
        .nmi_enable_o(nmi_enable_o), .irq_src_i(irq_src_i), .irq_edge_o(irq_edge_o),
        .dma_src_i(dma_src_i), .dma_req_o(dma_req_o));
    bad_cpu_model cpu (.clock_i(clock_i), .mem_rd_o(mem_rd_i), .mem_wr_o(mem_wr_i),
        .mem_addr_o(mem_addr_i), .io_rd_o(io_rd_i), .io_wr_o(io_wr_i),
        .io_addr_o(io_addr_i), .io_wdata_o(io_wdata_i));

    // ****************************************
    // Shared compare and cycle helpers
    // ****************************************
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Expected selects packed as boot, user, disk, external
    task mchk(input logic rd, input logic [19:0] a, input logic [3:0] e,
              input logic [1:0] pg);
        cpu.mem_cyc(rd, !rd, a);
        check({boot_flash_cs_o, user_flash_cs_o, flash_disk_cs_o, ext_bus_sel_o}, e);
        if (e[3])
            check(boot_page_o, pg);
    endtask : mchk

    task iochk(input logic rd, input logic [15:0] a, input logic [7:0] d,
               input logic cl);
        cpu.io_cyc(rd, !rd, a, d);
        check(io_claim_o, cl);
    endtask : iochk

    // ****************************************
    // Scenarios
    // ****************************************
    // Enables start cleared, so window and disk regions go external
    task t_reset;
        check({speaker_o, nmi_enable_o, user_page_o}, 16'h0000);
        mchk(1'b1, 20'hD1234, 4'h1, 2'h0);
        mchk(1'b1, 20'hE8000, 4'h1, 2'h0);
    endtask : t_reset

    // Glue pins copy their register one edge later, so wait a cycle
    task t_ports;
        iochk(1'b0, 16'h0061, 8'hFF, 1'b1);
        @(negedge clock_i) check(speaker_o, 16'h0003);
        iochk(1'b1, 16'h0061, 8'h00, 1'b1);
        check(io_rdata_o, 16'h0003);
        iochk(1'b0, 16'h1061, 8'h00, 1'b0);
        @(negedge clock_i) check(speaker_o, 16'h0003);
        iochk(1'b1, 16'h0062, 8'h00, 1'b0);
        check(io_rdata_o, 16'h0000);
        iochk(1'b0, 16'h00A0, 8'h80, 1'b1);
        @(negedge clock_i) check(nmi_enable_o, 16'h0001);
        iochk(1'b1, 16'h00A0, 8'h00, 1'b1);
        check(io_rdata_o, 16'h0080);
        iochk(1'b0, 16'h00A0, 8'h00, 1'b1);
        @(negedge clock_i) check(nmi_enable_o, 16'h0000);
    endtask : t_ports

    // Boundaries of every region except C0000, reads and writes
    task t_memory;
        iochk(1'b0, 16'h0181, 8'hFF, 1'b1);
        @(negedge clock_i) check(user_page_o, 16'h007F);
        iochk(1'b0, 16'h0180, 8'h03, 1'b1);
        mchk(1'b1, 20'hC1234, 4'h8, 2'h0);
        mchk(1'b0, 20'hC1234, 4'h1, 2'h0);
        mchk(1'b1, 20'hF0000, 4'h8, 2'h3);
        mchk(1'b0, 20'hFFFFF, 4'h8, 2'h3);
        mchk(1'b1, 20'hCFFFF, 4'h8, 2'h0);
        mchk(1'b1, 20'hD0000, 4'h4, 2'h0);
        mchk(1'b0, 20'hDFFFF, 4'h4, 2'h0);
        mchk(1'b1, 20'hE8000, 4'h2, 2'h0);
        mchk(1'b0, 20'hEFFFF, 4'h2, 2'h0);
        mchk(1'b1, 20'hE0000, 4'h1, 2'h0);
        mchk(1'b0, 20'hE7FFF, 4'h1, 2'h0);
        mchk(1'b1, 20'hA0000, 4'h1, 2'h0);
        mchk(1'b1, 20'h00000, 4'h1, 2'h0);
        iochk(1'b0, 16'h0180, 8'h00, 1'b1);
        mchk(1'b1, 20'hD0000, 4'h1, 2'h0);
    endtask : t_memory

    task t_irq_dma;
        @(negedge clock_i) irq_src_i = 8'hA5;
        @(negedge clock_i) check(irq_edge_o, 16'h00A5);
        @(negedge clock_i) check(irq_edge_o, 16'h0000);
        irq_src_i = 8'h08;
        dma_src_i = 3'h2;
        @(negedge clock_i) check(dma_req_o, 16'h0002);
        check(irq_edge_o, 16'h0008);
        dma_src_i = 3'h7;
        @(negedge clock_i) check(dma_req_o, 16'h0007);
        irq_src_i = 8'h00;
    endtask : t_irq_dma

    // ****************************************
    // Verdict and main sequence
    // ****************************************
    task conclude;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    // Hang guard: the whole run needs far fewer cycles than this
    initial
    begin
        #1ms;
        mismatches++;
        conclude();
    end

    initial
    begin
        repeat (8) @(posedge clock_i);
        @(negedge clock_i) rstn_i = 1'b1;
        t_reset();
        t_ports();
        t_memory();
        t_irq_dma();
        conclude();
    end
endmodule : board_address_decoder_test
